// ==== hw/mrs_pkg.sv ====
// Constants and types for the MCU reset sequencer
// What this block does
// RULE1: Pin reset only when option selects it
// RULE2: Hold program stopped while pin low
// RULE3: Wait release delay after pin release
// RULE4: Pin reset clears program counter to zero
// RULE5: Ignore low-supply pulses shorter than qualify time
// RULE6: Watchdog time-out in run acts as pin reset
// RULE7: Sleep time-out clears only PC and SP
// RULE8: Start-up delay depends on clock source
// RULE9: Power-on clears flags; pin/low-supply keeps them
// RULE10: Sleep time-out sets both flags
// RULE11: Power-on disables every interrupt
// RULE12: Power-on clears watchdog, starts it counting
// RULE13: Power-on switches timer counters off
// RULE14: Power-on: ports inputs, analog pins converter inputs
// RULE15: Power-on points stack pointer at top
// RULE16: Power-on sets port data and direction high
// RULE17: Synchronise reset requests before delay counters
`default_nettype none
package mrs_pkg;
	// Clock rate and documented times
	localparam int CLK_MHZ = 200;
	localparam int RELEASE_DELAY_MS = 100;
	localparam int RELEASE_DELAY_CYCLES = RELEASE_DELAY_MS * 1000 * CLK_MHZ;
	localparam int LOW_SUPPLY_QUALIFY_US = 1;
	localparam int LOW_SUPPLY_QUALIFY_CYCLES = LOW_SUPPLY_QUALIFY_US * CLK_MHZ;
	// Start-up timer lengths in clock cycles
	localparam int STARTUP_FAST_RC_CYCLES = 16;
	localparam int STARTUP_CRYSTAL_CYCLES = 1024;
	localparam int STARTUP_SLOW_RC_CYCLES = 2;
	// Reset values
	localparam logic [7:0] PORT_RESET_VALUE = 8'hFF;
	localparam logic [3:0] ANALOG_RESET_VALUE = 4'hF;
	localparam logic [2:0] STACK_TOP_VALUE = 3'h0;
	// System clock source selection
	typedef enum logic [2:0] {
		MRS_CLK_EXT_RC,
		MRS_CLK_FAST_RC,
		MRS_CLK_FAST_XTAL,
		MRS_CLK_SLOW_XTAL,
		MRS_CLK_SLOW_RC
	} mrs_clk_src_type;
	// Sequencer states
	typedef enum logic [1:0] {
		MRS_HOLD,
		MRS_RELEASE,
		MRS_STARTUP,
		MRS_RUN
	} mrs_state_type;
endpackage : mrs_pkg
`default_nettype wire

// ==== hw/mrs_reset_sequencer.sv ====
// Reset sequencer: merges reset sources, times start-up, keeps flags
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_sequencer #(
	parameter int RELEASE_CYCLES = mrs_pkg::RELEASE_DELAY_CYCLES,
	parameter int QUALIFY_CYCLES = mrs_pkg::LOW_SUPPLY_QUALIFY_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ext_reset_n_pin,
	input wire logic pin_reset_option,
	input wire logic low_supply_detect,
	input wire logic low_supply_enable,
	input wire mrs_pkg::mrs_clk_src_type clk_source,
	input wire logic wdt_timeout,
	input wire logic sleep_mode,
	output logic cpu_run,
	output logic pc_clear,
	output logic sp_to_top,
	output logic state_clear,
	output logic por_init,
	output logic wdt_timeout_flag,
	output logic powerdown_flag,
	output logic shared_port_pin_in,
	output logic low_supply_reset
);
	import mrs_pkg::*;

	// Synchroniser stages
	// Bit 0 may go metastable, so only bit 1 feeds logic
	logic [1:0] pin_sync; // Reset pin, idles high
	logic [1:0] lvd_sync; // Low-supply indication, idles low
	logic [1:0] next_pin_sync;
	logic [1:0] next_lvd_sync;
	// Low-supply qualification counter
	// Saturates at the qualify count
	logic [31:0] lvd_count;
	logic [31:0] next_lvd_count;
	logic lvd_hit;
	// Sequencer state and delay counter
	// One counter serves release and start-up in turn
	mrs_state_type state;
	mrs_state_type next_state;
	logic [31:0] delay_count;
	logic [31:0] next_delay_count;
	logic por_pending;
	logic next_por_pending;
	// Registered outputs
	logic next_cpu_run;
	logic next_pc_clear;
	logic next_sp_to_top;
	logic next_state_clear;
	logic next_por_init;
	logic next_wdt_timeout_flag;
	logic next_powerdown_flag;
	logic next_port_in;
	logic next_low_supply_reset;
	// Derived helpers
	// Counters are 32 bits to hold the full release delay
	logic pin_asserted;
	logic [31:0] startup_cycles;

	// Pin reset qualified by option [RULE1]
	// Option off leaves the pin a plain port input
	assign pin_asserted = pin_reset_option & ~pin_sync[1];
	// Low-supply indication long enough [RULE5]
	assign lvd_hit = low_supply_enable & lvd_sync[1] &
		(lvd_count >= QUALIFY_CYCLES);

	// Start-up length by clock source
	// Ranged figures take the upper end, never short
	always_comb begin
		unique case (clk_source)
			MRS_CLK_EXT_RC, MRS_CLK_FAST_RC: begin
				startup_cycles = STARTUP_FAST_RC_CYCLES; // [RULE8]
			end
			MRS_CLK_FAST_XTAL, MRS_CLK_SLOW_XTAL: begin
				startup_cycles = STARTUP_CRYSTAL_CYCLES; // [RULE8]
			end
			MRS_CLK_SLOW_RC: begin
				startup_cycles = STARTUP_SLOW_RC_CYCLES; // [RULE8]
			end
			default: begin
				// Illegal codes take the RC length
				startup_cycles = STARTUP_FAST_RC_CYCLES;
			end
		endcase
	end

	// Input synchronisers and low-supply filter
	always_comb begin
		// Shift both inputs into two-stage synchronisers
		next_pin_sync = {pin_sync[0], ext_reset_n_pin}; // [RULE17]
		next_lvd_sync = {lvd_sync[0], low_supply_detect}; // [RULE17]
		// Count only while indication persists
		if (lvd_sync[1] && low_supply_enable) begin
			next_lvd_count = (lvd_count >= QUALIFY_CYCLES) ? lvd_count :
				lvd_count + 32'h0000_0001; // [RULE5]
		end else begin
			next_lvd_count = 32'h0; // [RULE5]
		end
		// Port side sees the pin even with reset selected
		next_port_in = pin_sync[1];
	end

	// Sequencer and flag control
	// Pin and low-supply requests win over every state
	always_comb begin
		// Strobes default low, state holds
		next_state = state;
		next_delay_count = delay_count;
		next_por_pending = por_pending;
		next_cpu_run = 1'b0;
		next_pc_clear = 1'b0;
		next_sp_to_top = 1'b0;
		next_state_clear = 1'b0;
		next_por_init = 1'b0;
		// Flags move only on a time-out; rst_n clears them
		next_wdt_timeout_flag = wdt_timeout_flag;
		next_powerdown_flag = powerdown_flag;
		next_low_supply_reset = lvd_hit;
		if (pin_asserted || lvd_hit) begin
			// Full reset, flags kept, program held [RULE2] [RULE4] [RULE9]
			next_state = MRS_HOLD;
			next_pc_clear = 1'b1;
			next_sp_to_top = 1'b1;
			next_state_clear = 1'b1;
		end else begin
			// No request pending: walk the sequence
			unique case (state)
				MRS_HOLD: begin
					// One cycle of full reset once requests drop
					next_pc_clear = 1'b1;
					next_sp_to_top = 1'b1;
					next_state_clear = 1'b1;
					next_por_init = por_pending;
					next_delay_count = 32'h0;
					next_state = MRS_RELEASE;
				end
				MRS_RELEASE: begin
					// Extra delay after release [RULE3]
					next_pc_clear = 1'b1;
					next_por_init = por_pending;
					next_delay_count = delay_count + 32'h0000_0001;
					// Last cycle of the delay starts the timer
					if (delay_count + 32'h0000_0001 >= RELEASE_CYCLES) begin
						next_delay_count = 32'h0;
						next_state = MRS_STARTUP;
					end
				end
				MRS_STARTUP: begin
					// Start-up timer [RULE8]
					next_pc_clear = 1'b1;
					next_por_init = por_pending;
					next_delay_count = delay_count + 32'h0000_0001;
					if (delay_count + 32'h0000_0001 >= startup_cycles) begin
						// Timer done: release the program counter
						next_state = MRS_RUN;
						next_por_pending = 1'b0;
						next_por_init = 1'b0;
						next_pc_clear = 1'b0;
						next_cpu_run = 1'b1;
					end
				end
				MRS_RUN: begin
					// Program runs until a time-out
					next_cpu_run = 1'b1;
					if (wdt_timeout && sleep_mode) begin
						// Only PC and SP cleared, both flags set [RULE7] [RULE10]
						next_pc_clear = 1'b1;
						next_sp_to_top = 1'b1;
						next_wdt_timeout_flag = 1'b1;
						next_powerdown_flag = 1'b1;
					end else if (wdt_timeout) begin
						// Acts like pin reset, time-out flag set [RULE6]
						next_wdt_timeout_flag = 1'b1;
						next_cpu_run = 1'b0;
						next_pc_clear = 1'b1;
						next_sp_to_top = 1'b1;
						next_state_clear = 1'b1;
						next_delay_count = 32'h0;
						next_state = MRS_RELEASE;
					end
				end
			endcase
		end
	end

	// State registers; power-on clears flags and requests init
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Synchronisers rest at idle so no false edge follows
			pin_sync <= 2'b11;
			lvd_sync <= 2'b00;
			lvd_count <= 32'h0;
			// Sequencer starts by holding the program
			state <= MRS_HOLD;
			delay_count <= 32'h0;
			por_pending <= 1'b1; // [RULE11] [RULE12] [RULE13] [RULE14] [RULE16]
			// Program held, full reset, power-on init
			cpu_run <= 1'b0;
			pc_clear <= 1'b1; // [RULE4]
			sp_to_top <= 1'b1; // [RULE15]
			state_clear <= 1'b1;
			por_init <= 1'b1; // [RULE11] [RULE13] [RULE14] [RULE16]
			// Only power-on clears the reset flags
			wdt_timeout_flag <= 1'b0; // [RULE9]
			powerdown_flag <= 1'b0; // [RULE9]
			shared_port_pin_in <= 1'b1;
			low_supply_reset <= 1'b0;
		end else begin
			// Register every next value
			pin_sync <= next_pin_sync;
			lvd_sync <= next_lvd_sync;
			lvd_count <= next_lvd_count;
			state <= next_state;
			delay_count <= next_delay_count;
			por_pending <= next_por_pending;
			cpu_run <= next_cpu_run;
			pc_clear <= next_pc_clear;
			sp_to_top <= next_sp_to_top;
			state_clear <= next_state_clear;
			por_init <= next_por_init;
			wdt_timeout_flag <= next_wdt_timeout_flag;
			powerdown_flag <= next_powerdown_flag;
			shared_port_pin_in <= next_port_in;
			low_supply_reset <= next_low_supply_reset;
		end
	end
endmodule : mrs_reset_sequencer
`default_nettype wire

// ==== verification/mrs_reset_sequencer_checker.sv ====
// Port checker for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_sequencer_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ext_reset_n_pin,
	input wire logic pin_reset_option,
	input wire logic wdt_timeout,
	input wire logic sleep_mode,
	input wire logic cpu_run,
	input wire logic pc_clear,
	input wire logic sp_to_top,
	input wire logic state_clear,
	input wire logic por_init,
	input wire logic wdt_timeout_flag,
	input wire logic powerdown_flag,
	input wire logic low_supply_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Watchdog hit while asleep
	sequence s_sleep_hit;
		cpu_run && sleep_mode && wdt_timeout;
	endsequence
	// Watchdog hit while running awake
	sequence s_run_hit;
		cpu_run && !sleep_mode && wdt_timeout;
	endsequence
	a_pin_holds_off: assert property (
		(pin_reset_option && !ext_reset_n_pin)[*4] |-> !cpu_run)
		else $error("pin low but cpu running");
	a_pc_held_zero: assert property (!cpu_run |-> pc_clear)
		else $error("pc not held while stopped");
	a_run_timeout: assert property (s_run_hit
		|=> wdt_timeout_flag && !cpu_run && state_clear)
		else $error("run timeout");
	a_sleep_timeout: assert property (s_sleep_hit
		|=> cpu_run && pc_clear && sp_to_top && !state_clear
		&& wdt_timeout_flag && powerdown_flag)
		else $error("sleep timeout");
	a_low_supply_stop: assert property (
		low_supply_reset[*2] |-> !cpu_run)
		else $error("low supply but running");
	a_por_flags: assert property (
		por_init |-> !wdt_timeout_flag && !powerdown_flag)
		else $error("flags set in power-on");
	a_por_clear: assert property (
		por_init |-> pc_clear && !cpu_run)
		else $error("power-on program not held");
	a_por_sp_top: assert property (
		por_init && state_clear |-> sp_to_top)
		else $error("power-on stack pointer not at top");
	a_pd_flag_kept: assert property (
		!wdt_timeout |=> $stable(powerdown_flag))
		else $error("powerdown flag moved");
endmodule : mrs_reset_sequencer_checker
`default_nettype wire

// ==== verification/mrs_reset_sequencer_tb.sv ====
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_sequencer_tb;
	import mrs_pkg::*;
	logic clk = 0, rst_n = 0, hold = 0, pin_reset_option = 1;
	logic low_supply_detect = 0, low_supply_enable = 1;
	logic wdt_timeout = 0, sleep_mode = 0, ext_reset_n_pin, cpu_run;
	logic pc_clear, sp_to_top, state_clear, por_init, wdt_timeout_flag;
	logic powerdown_flag, shared_port_pin_in, low_supply_reset;
	mrs_clk_src_type clk_source = MRS_CLK_EXT_RC;
	int num_errors = 0, comparisons = 0, n;
	// Expected start-up length per clock source code
	int startup[5] = '{
		STARTUP_FAST_RC_CYCLES,
		STARTUP_FAST_RC_CYCLES,
		STARTUP_CRYSTAL_CYCLES,
		STARTUP_CRYSTAL_CYCLES,
		STARTUP_SLOW_RC_CYCLES
	};
	logic [31:0] seed = 32'hDD7D;
	always #2.5 clk = ~clk;
	mrs_supervisor sup (
		.clk(clk),
		.hold(hold),
		.ext_reset_n_pin(ext_reset_n_pin)
	);
	mrs_reset_sequencer #(
		.RELEASE_CYCLES(10),
		.QUALIFY_CYCLES(4)
	) DUT (
		.clk(clk),
		.rst_n(rst_n),
		.ext_reset_n_pin(ext_reset_n_pin),
		.pin_reset_option(pin_reset_option),
		.low_supply_detect(low_supply_detect),
		.low_supply_enable(low_supply_enable),
		.clk_source(clk_source),
		.wdt_timeout(wdt_timeout),
		.sleep_mode(sleep_mode),
		.cpu_run(cpu_run),
		.pc_clear(pc_clear),
		.sp_to_top(sp_to_top),
		.state_clear(state_clear),
		.por_init(por_init),
		.wdt_timeout_flag(wdt_timeout_flag),
		.powerdown_flag(powerdown_flag),
		.shared_port_pin_in(shared_port_pin_in),
		.low_supply_reset(low_supply_reset)
	);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// Cycle counts must fall inside the allowed span
	task automatic cmp_cycles(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, lo);
		end
	endtask : cmp_cycles
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	// Counts cycles until the cpu may run, bounded
	task automatic wait_run();
		for (n = 0; cpu_run !== 1'b1 && n < 2000; n++) cyc(1);
	endtask : wait_run
	task automatic finish_test();
		if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test
	// Main sequence: one power-on per clock source, then each reset kind
	initial begin
		foreach (startup[i]) begin
			rst_n = 0;
			clk_source = mrs_clk_src_type'(i);
			cyc(20);
			cmp({por_init, wdt_timeout_flag, powerdown_flag, cpu_run}, 8);
			rst_n = 1;
			wait_run();
			cmp_cycles(n, 11 + startup[i], 14 + startup[i]);
			cmp(por_init, 0);
		end
		wdt_timeout = 1;
		cyc(1);
		wdt_timeout = 0;
		cmp({cpu_run, wdt_timeout_flag, powerdown_flag, state_clear}, 5);
		wait_run();
		sleep_mode = 1;
		wdt_timeout = 1;
		cyc(1);
		wdt_timeout = 0;
		cmp({cpu_run, pc_clear, sp_to_top, wdt_timeout_flag, powerdown_flag}, 31);
		cyc(1);
		cmp({pc_clear, state_clear}, 0);
		sleep_mode = 0;
		hold = 1;
		cyc(8);
		cmp({cpu_run, pc_clear, wdt_timeout_flag, powerdown_flag}, 7);
		hold = 0;
		wait_run();
		cmp_cycles(n, 14, 17);
		pin_reset_option = 0;
		hold = 1;
		cyc(8);
		cmp({cpu_run, shared_port_pin_in}, 2);
		hold = 0;
		cyc(4);
		pin_reset_option = 1;
		low_supply_detect = 1;
		cyc(1 + rnd() % 3);
		low_supply_detect = 0;
		cyc(8);
		cmp({cpu_run, low_supply_reset}, 2);
		low_supply_enable = 0;
		low_supply_detect = 1;
		cyc(10);
		cmp({cpu_run, low_supply_reset}, 2);
		low_supply_detect = 0;
		low_supply_enable = 1;
		cyc(4);
		low_supply_detect = 1;
		cyc(10);
		cmp({cpu_run, low_supply_reset}, 1);
		low_supply_detect = 0;
		wait_run();
		cmp(cpu_run, 1);
		finish_test();
	end
	// Hang guard
	initial begin
		#200000;
		num_errors++;
		finish_test();
	end
endmodule : mrs_reset_sequencer_tb
bind mrs_reset_sequencer mrs_reset_sequencer_checker chk (
	.clk(clk),
	.rst_n(rst_n),
	.ext_reset_n_pin(ext_reset_n_pin),
	.pin_reset_option(pin_reset_option),
	.wdt_timeout(wdt_timeout),
	.sleep_mode(sleep_mode),
	.cpu_run(cpu_run),
	.pc_clear(pc_clear),
	.sp_to_top(sp_to_top),
	.state_clear(state_clear),
	.por_init(por_init),
	.wdt_timeout_flag(wdt_timeout_flag),
	.powerdown_flag(powerdown_flag),
	.low_supply_reset(low_supply_reset)
);
`default_nettype wire

// ==== verification/mrs_supervisor.sv ====
// Reset supervisor model driving the shared reset pin
`timescale 1ns/1ps
`default_nettype none
module mrs_supervisor (
	input wire logic clk,
	input wire logic hold,
	output var logic ext_reset_n_pin = 1'b1
);
	// Pulls pin low on command, pull-up level when released
	always @(posedge clk) ext_reset_n_pin <= !hold;
endmodule : mrs_supervisor
`default_nettype wire
